// ---- hdl/hefs_top.sv ----
// Host event flag generator with Avalon-MM register slave and gated interrupt line.
//
// Behaviour
// RULE_01: Flag 5 shows synchronous command responses queued.
// RULE_02: Flag 6 shows async responses or debug data.
// RULE_03: Async mode routes command responses to flag 6.
// RULE_04: Queue flag one means data, zero none.
// RULE_05: Fatal error sets flag 7.
// RULE_06: Flag 7 set by reset, cleared after upload.
// RULE_07: No interrupt before host configures interrupt type; only host_irq is gated, irq follows masked status from reset.
// RULE_08: Warm reset may restore retained interrupt configuration.
// RULE_09: Flags readable in status register at 0x2D.
// RULE_10: Flags clear when drained; writes ignored.
`default_nettype none

module hefs_top
  import hefs_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire logic [HEFS_ADDR_W-1:0] avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  input  wire logic [3:0]             avs_byteenable,
  output var  logic [31:0]            avs_readdata,
  output var  logic                   avs_waitrequest,
  input  wire logic                   queue_cmd_resp,
  input  wire logic                   queue_async_data,
  input  wire logic                   fatal_error,
  input  wire logic                   init_done,
  input  wire logic                   upload_start,
  input  wire logic                   warm_reset_cause,
  input  wire logic                   retained_cfg_valid,
  input  wire logic [7:0]             retained_cfg,
  output var  logic [7:0]             host_flags,
  output var  logic                   host_irq,
  output var  logic                   irq
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic                 ack;
    logic [31:0]          rdata;
    logic                 async_mode;
    logic [7:0]           irq_cfg;
    logic                 irq_cfg_valid;
    logic                 reset_fault;
    hefs_boot_t           st;
    logic [1:0]           q_flags;
    logic [HEFS_EV_W-1:0] int_status;
    logic [HEFS_EV_W-1:0] int_mask;
  } hefs_state_t;

  hefs_state_t state_reg;
  hefs_state_t state_next;

  function automatic logic hefs_hit(input logic [HEFS_ADDR_W-1:0] a,
                                    input logic [HEFS_ADDR_W-1:0] r);
    hefs_hit = (a == r);
  endfunction : hefs_hit

  // ==========================================================================
  // Bus handshake
  // ==========================================================================
  // One wait state: read data is registered in the first cycle and stands at
  // the completing edge, which keeps the read path off the address decoder.
  logic       bus_req;
  logic       bus_done;
  logic       wr_done;
  logic       rd_done;
  logic       status_rd;
  logic [1:0] q_live;
  logic [HEFS_EV_W-1:0] events;
  logic       irq_pending;

  assign bus_req         = avs_read || avs_write;
  assign avs_waitrequest = bus_req && !state_reg.ack;
  assign bus_done        = bus_req && state_reg.ack;
  assign wr_done         = bus_done && avs_write && avs_byteenable[0];
  assign rd_done         = bus_done && avs_read;
  assign status_rd       = rd_done && hefs_hit(avs_address, HEFS_ADDR_INT_STATUS);

  // ==========================================================================
  // Queue flag derivation
  // ==========================================================================
  always_comb begin
    q_live = 2'b00;
    if (!state_reg.async_mode) begin
      q_live[0] = queue_cmd_resp; // [RULE_01]
    end
    q_live[1] = queue_async_data || (state_reg.async_mode && queue_cmd_resp); // [RULE_02] [RULE_03]
  end

  assign events[HEFS_EV_STATUS] = q_live[0] && !state_reg.q_flags[0];
  assign events[HEFS_EV_DEBUG]  = q_live[1] && !state_reg.q_flags[1];
  assign events[HEFS_EV_FAULT]  = fatal_error;

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    state_next     = state_reg;
    state_next.ack = bus_req && !state_reg.ack;
    // Level inputs drop straight back to zero once the host drains the queue.
    state_next.q_flags = q_live; // [RULE_04] [RULE_10]

    if (bus_req && !state_reg.ack && avs_read) begin
      state_next.rdata = HEFS_RDATA_RST;
      if (hefs_hit(avs_address, HEFS_ADDR_FLAGS)) begin
        state_next.rdata[7:0] = host_flags; // [RULE_09]
      end else if (hefs_hit(avs_address, HEFS_ADDR_LINK_CFG)) begin
        state_next.rdata[HEFS_LINK_ASYNC_BIT] = state_reg.async_mode;
      end else if (hefs_hit(avs_address, HEFS_ADDR_IRQ_CFG)) begin
        state_next.rdata[7:0] = state_reg.irq_cfg;
      end else if (hefs_hit(avs_address, HEFS_ADDR_INT_STATUS)) begin
        state_next.rdata[HEFS_EV_W-1:0] = state_reg.int_status;
      end else if (hefs_hit(avs_address, HEFS_ADDR_INT_MASK)) begin
        state_next.rdata[HEFS_EV_W-1:0] = state_reg.int_mask;
      end
    end

    // The flag register has no write path at all.
    if (wr_done) begin // [RULE_10]
      if (hefs_hit(avs_address, HEFS_ADDR_LINK_CFG)) begin
        state_next.async_mode = avs_writedata[HEFS_LINK_ASYNC_BIT];
      end
      if (hefs_hit(avs_address, HEFS_ADDR_IRQ_CFG)) begin
        state_next.irq_cfg       = avs_writedata[7:0];
        state_next.irq_cfg_valid = 1'b1; // [RULE_07]
      end
      if (hefs_hit(avs_address, HEFS_ADDR_INT_MASK)) begin
        state_next.int_mask = avs_writedata[HEFS_EV_W-1:0];
      end
    end

    // Read clears, but an event in the same cycle survives.
    if (status_rd) begin
      state_next.int_status = events;
    end else begin
      state_next.int_status = state_reg.int_status | events;
    end

    case (state_reg.st)
      HEFS_ST_CAPTURE: begin
        // Retained configuration is caught one cycle after release.
        if (warm_reset_cause && retained_cfg_valid) begin
          state_next.irq_cfg       = retained_cfg; // [RULE_08]
          state_next.irq_cfg_valid = 1'b1;
        end
        state_next.st = HEFS_ST_INIT;
      end
      HEFS_ST_INIT: begin
        if (init_done) begin
          state_next.st = HEFS_ST_WAIT_UPLOAD;
        end
      end
      HEFS_ST_WAIT_UPLOAD: begin
        if (upload_start) begin
          state_next.st          = HEFS_ST_RUN;
          state_next.reset_fault = 1'b0; // [RULE_06]
        end
      end
      HEFS_ST_RUN: begin
        state_next.st = HEFS_ST_RUN;
      end
      default: begin
        state_next.st = HEFS_ST_INIT;
      end
    endcase

    if (fatal_error) begin
      state_next.reset_fault = 1'b1; // [RULE_05]
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg.ack           <= 1'b0;
      state_reg.rdata         <= HEFS_RDATA_RST;
      state_reg.async_mode    <= 1'b0;
      state_reg.irq_cfg       <= HEFS_IRQ_CFG_RST;
      state_reg.irq_cfg_valid <= 1'b0;
      state_reg.reset_fault   <= 1'b1; // [RULE_06]
      state_reg.st            <= HEFS_ST_CAPTURE;
      state_reg.q_flags       <= 2'b00;
      state_reg.int_status    <= 3'h0;
      state_reg.int_mask      <= HEFS_INT_MASK_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  always_comb begin
    host_flags                       = 8'h00;
    host_flags[HEFS_FLAG_STATUS_BIT] = state_reg.q_flags[0];
    host_flags[HEFS_FLAG_DEBUG_BIT]  = state_reg.q_flags[1];
    host_flags[HEFS_FLAG_RESET_BIT]  = state_reg.reset_fault;
  end

  assign avs_readdata = state_reg.rdata;
  assign irq_pending  = |(state_reg.int_status & state_reg.int_mask);
  assign irq          = irq_pending;

  // Until a type is configured the pad stays low: its polarity is unknown,
  // so any level could read as an assertion on the host side.
  assign host_irq = state_reg.irq_cfg_valid && state_reg.irq_cfg[HEFS_IRQ_EN_BIT] &&
                    (irq_pending ^ state_reg.irq_cfg[HEFS_IRQ_POL_BIT]); // [RULE_07]

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  sequence drain_seq;
    queue_cmd_resp && !queue_async_data ##1 !queue_cmd_resp && !queue_async_data;
  endsequence

  sequence upload_seq;
    state_reg.st == HEFS_ST_WAIT_UPLOAD && upload_start && !fatal_error;
  endsequence

  sequence flags_read_seq;
    avs_read && !avs_waitrequest && hefs_hit(avs_address, HEFS_ADDR_FLAGS);
  endsequence

  status_sync_a: assert property ( // [RULE_01]
    host_flags[5] == $past(queue_cmd_resp && !state_reg.async_mode))
    else $error("Status flag does not follow synchronous responses.");

  debug_async_a: assert property ( // [RULE_02]
    $past(queue_async_data) |-> host_flags[6])
    else $error("Debug flag missing for queued async data.");

  async_route_a: assert property ( // [RULE_03]
    $past(state_reg.async_mode && queue_cmd_resp) |-> host_flags[6] && !host_flags[5])
    else $error("Async mode response not routed to debug flag.");

  flag_encode_a: assert property ( // [RULE_04]
    $past(!queue_cmd_resp && !queue_async_data) |-> host_flags[6:5] == 2'b00)
    else $error("Queue flag set while queue is empty.");

  fatal_flag_a: assert property ( // [RULE_05]
    fatal_error |=> host_flags[7] [*2])
    else $error("Fatal error did not set reset flag.");

  reset_clear_a: assert property ( // [RULE_06]
    upload_seq |=> !host_flags[7] && state_reg.st == HEFS_ST_RUN)
    else $error("Reset flag not cleared at upload start.");

  reset_set_a: assert property ( // [RULE_06]
    $fell(reset) |-> host_flags[7] && state_reg.st == HEFS_ST_CAPTURE)
    else $error("Reset flag not set after reset.");

  irq_gate_a: assert property ( // [RULE_07]
    !state_reg.irq_cfg_valid |-> !host_irq)
    else $error("Interrupt line driven before configuration.");

  warm_restore_a: assert property ( // [RULE_08]
    state_reg.st == HEFS_ST_CAPTURE && warm_reset_cause && retained_cfg_valid
    |=> state_reg.irq_cfg_valid && state_reg.irq_cfg == $past(retained_cfg))
    else $error("Retained interrupt configuration not restored.");

  flags_read_a: assert property ( // [RULE_09]
    flags_read_seq |-> avs_readdata[7:0] == $past(host_flags) &&
                       avs_readdata[31:8] == 24'h000000)
    else $error("Flag register read returned wrong value.");

  drain_clear_a: assert property ( // [RULE_10]
    drain_seq |=> host_flags[6:5] == 2'b00)
    else $error("Queue flag stuck after queue drained.");

  sticky_keep_a: assert property (
    events != 3'h0 |=> (state_reg.int_status & $past(events)) == $past(events))
    else $error("Interrupt event lost.");

  wait_bound_a: assert property (
    bus_req && avs_waitrequest |=> !avs_waitrequest)
    else $error("Bus answer later than one wait state.");

  // ==========================================================================
  // Register path checks
  // ==========================================================================
  // link_write_a, cfg_write_a, byte_gate_a and flag_write_a guard the write side of the map: a lost
  // byte-enable gate or a misrouted decode would otherwise only show up as odd interrupt timing.
  sequence link_wr_seq;
    wr_done && hefs_hit(avs_address, HEFS_ADDR_LINK_CFG);
  endsequence

  sequence gated_wr_seq;
    bus_done && avs_write && !avs_byteenable[0];
  endsequence

  status_clear_a: assert property (
    status_rd |=> state_reg.int_status == $past(events))
    else $error("Status read did not clear pending events.");

  link_write_a: assert property ( // [RULE_03]
    link_wr_seq |=> state_reg.async_mode == $past(avs_writedata[HEFS_LINK_ASYNC_BIT]))
    else $error("Async mode write did not land.");

  cfg_write_a: assert property ( // [RULE_07]
    wr_done && hefs_hit(avs_address, HEFS_ADDR_IRQ_CFG) |=> state_reg.irq_cfg_valid)
    else $error("Interrupt configuration write not marked valid.");

  byte_gate_a: assert property (
    gated_wr_seq |=> $stable(state_reg.int_mask) && $stable(state_reg.async_mode))
    else $error("Write without low byte enable changed a register.");

  flag_low_a: assert property ( // [RULE_09]
    host_flags[4:0] == 5'h00)
    else $error("Unused flag bits not zero.");

  early_upload_a: assert property ( // [RULE_06]
    state_reg.st == HEFS_ST_INIT && upload_start |=> host_flags[7])
    else $error("Reset flag cleared before initialisation finished.");

  // Writes to the flag register have no path into the state at all.
  flag_write_a: assert property ( // [RULE_10]
    wr_done && hefs_hit(avs_address, HEFS_ADDR_FLAGS) && !fatal_error && !upload_start
    |=> host_flags[7] == $past(host_flags[7]))
    else $error("Flag register write changed the reset flag.");

endmodule : hefs_top

`default_nettype wire

// ---- include/hefs_pkg.sv ----
// Package of register map, field positions and state codes for the host event flag block.
`default_nettype none

package hefs_pkg;

  // ==========================================================================
  // Register indices and byte addresses
  // ==========================================================================
  localparam logic [7:0] HEFS_IDX_LINK_CFG   = 8'h06;
  localparam logic [7:0] HEFS_IDX_IRQ_CFG    = 8'h07;
  localparam logic [7:0] HEFS_IDX_FLAGS      = 8'h2D;
  localparam logic [7:0] HEFS_IDX_INT_STATUS = 8'h30;
  localparam logic [7:0] HEFS_IDX_INT_MASK   = 8'h31;

  localparam int          HEFS_ADDR_W       = 10;
  localparam logic [9:0]  HEFS_ADDR_LINK_CFG   = {HEFS_IDX_LINK_CFG, 2'b00};
  localparam logic [9:0]  HEFS_ADDR_IRQ_CFG    = {HEFS_IDX_IRQ_CFG, 2'b00};
  localparam logic [9:0]  HEFS_ADDR_FLAGS      = {HEFS_IDX_FLAGS, 2'b00};
  localparam logic [9:0]  HEFS_ADDR_INT_STATUS = {HEFS_IDX_INT_STATUS, 2'b00};
  localparam logic [9:0]  HEFS_ADDR_INT_MASK   = {HEFS_IDX_INT_MASK, 2'b00};

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int HEFS_FLAG_STATUS_BIT = 5;
  localparam int HEFS_FLAG_DEBUG_BIT  = 6;
  localparam int HEFS_FLAG_RESET_BIT  = 7;
  localparam int HEFS_LINK_ASYNC_BIT  = 0;
  localparam int HEFS_IRQ_EN_BIT      = 0;
  localparam int HEFS_IRQ_POL_BIT     = 1;
  localparam int HEFS_EV_STATUS       = 0;
  localparam int HEFS_EV_DEBUG        = 1;
  localparam int HEFS_EV_FAULT        = 2;
  localparam int HEFS_EV_W            = 3;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [7:0]          HEFS_IRQ_CFG_RST  = 8'h00;
  localparam logic [HEFS_EV_W-1:0] HEFS_INT_MASK_RST = 3'h0;
  localparam logic [31:0]         HEFS_RDATA_RST    = 32'h0000_0000;

  // ==========================================================================
  // Boot phases
  // ==========================================================================
  typedef enum logic [1:0] {
    HEFS_ST_CAPTURE     = 2'b00,
    HEFS_ST_INIT        = 2'b01,
    HEFS_ST_WAIT_UPLOAD = 2'b10,
    HEFS_ST_RUN         = 2'b11
  } hefs_boot_t;

endpackage : hefs_pkg

`default_nettype wire

// ---- verification/hefs_host_model.sv ----
// Host processor model that reaches the flag block over Avalon-MM.
`default_nettype none

module hefs_host_model
  import hefs_pkg::*;
(
  input  wire logic                   clk,
  output var  logic [HEFS_ADDR_W-1:0] avs_address,
  output var  logic                   avs_read,
  output var  logic                   avs_write,
  output var  logic [31:0]            avs_writedata,
  output var  logic [3:0]             avs_byteenable,
  input  wire logic [31:0]            avs_readdata,
  input  wire logic                   avs_waitrequest
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    avs_address    = '0;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h0000_0000;
    avs_byteenable = 4'h0;
  end

  // ==========================================================================
  // Bus cycle
  // ==========================================================================
  // The request is held until an edge sees waitrequest low; the bench
  // watchdog is the only bound on a slave that never answers.
  task automatic xfer(input logic w, input logic [HEFS_ADDR_W-1:0] a, input logic [31:0] d,
                      input logic [3:0] be);
    @(posedge clk);
    avs_read       <= !w;
    avs_write      <= w;
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_read       <= 1'b0;
    avs_write      <= 1'b0;
  endtask : xfer

endmodule : hefs_host_model

`default_nettype wire

// ---- verification/tb_top.sv ----
// Self-checking bench for the host event flag block.
`default_nettype none

module tb_top
  import hefs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic                   clk = 1'b0;
  logic                   reset = 1'b1;
  logic [HEFS_ADDR_W-1:0] avs_address;
  logic                   avs_read, avs_write, avs_waitrequest;
  logic [31:0]            avs_writedata, avs_readdata;
  logic [3:0]             avs_byteenable;
  logic [4:0]             ev = 5'h00;
  logic [2:0]             warm = 3'h0;
  logic [7:0]             host_flags;
  logic                   host_irq, irq;
  logic [31:0]            expq[$];
  logic [31:0]            seed = 32'h2de4;
  int                     mismatches = 0;
  int                     check_count = 0;

  initial forever #10 clk = ~clk;

  hefs_top hefs_top_i (.clk(clk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .queue_cmd_resp(ev[4]),
    .queue_async_data(ev[3]), .fatal_error(ev[2]), .init_done(ev[1]),
    .upload_start(ev[0]), .warm_reset_cause(warm[2]), .retained_cfg_valid(warm[1]),
    .retained_cfg({7'h00, warm[0]}), .host_flags(host_flags), .host_irq(host_irq),
    .irq(irq));

  hefs_host_model hefs_host_model_i (.clk(clk), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));

  // ==========================================================================
  // Helpers
  // ==========================================================================
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t pin %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t read got %h exp %h", $time, got, exp);
    end
  endtask : chk_rd

  // Read data is taken at the edge that completes the read.
  always @(posedge clk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      if (expq.size() == 0) chk_rd(avs_readdata, 32'hFFFF_FFFF);
      else chk_rd(avs_readdata, expq.pop_front());
    end
  end

  task automatic rd(input logic [HEFS_ADDR_W-1:0] a, input logic [31:0] e);
    expq.push_back(e);
    hefs_host_model_i.xfer(1'b0, a, 32'h0000_0000, 4'hF);
  endtask : rd

  task automatic wr(input logic [HEFS_ADDR_W-1:0] a, input logic [31:0] d);
    hefs_host_model_i.xfer(1'b1, a, d, 4'hF);
  endtask : wr

  task automatic drv(input logic [4:0] v);
    @(posedge clk);
    ev <= v;
  endtask : drv

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic do_reset(input logic [2:0] w);
    @(posedge clk);
    reset <= 1'b1;
    warm  <= w;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    tick(2);
  endtask : do_reset

  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test

  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    finish_test();
  end

  // ==========================================================================
  // Tests
  // ==========================================================================
  initial begin
    do_reset(3'h0);
    chk(host_flags, 8'h80, "reset");
    chk({7'h00, host_irq}, 8'h00, "hirq");
    rd(HEFS_ADDR_FLAGS, 32'h0000_0080);
    wr(HEFS_ADDR_INT_MASK, 32'h0000_0007);
    // A write without its low byte enabled must leave the mask alone.
    hefs_host_model_i.xfer(1'b1, HEFS_ADDR_INT_MASK, 32'h0000_0000, 4'hE);
    rd(HEFS_ADDR_INT_MASK, 32'h0000_0007);
    drv(5'h10);
    tick(1);
    chk(host_flags, 8'hA0, "sync");
    chk({6'h00, irq, host_irq}, 8'h02, "unconf");
    rd(HEFS_ADDR_INT_STATUS, 32'h0000_0001);
    drv(5'h00);
    tick(1);
    chk({7'h00, irq}, 8'h00, "clr");
    chk(host_flags, 8'h80, "drain");
    wr(HEFS_ADDR_FLAGS, $random(seed));
    wr(10'h3FC, $random(seed));
    rd(HEFS_ADDR_FLAGS, 32'h0000_0080);
    rd(10'h3FC, 32'h0000_0000);
    $display("test sync done");
    wr(HEFS_ADDR_LINK_CFG, 32'h0000_0001);
    drv(5'h10);
    tick(1);
    chk(host_flags, 8'hC0, "async cmd");
    drv(5'h08);
    tick(1);
    chk(host_flags, 8'hC0, "debug");
    drv(5'h00);
    tick(1);
    chk(host_flags, 8'h80, "debug drain");
    rd(HEFS_ADDR_INT_STATUS, 32'h0000_0002);
    rd(HEFS_ADDR_LINK_CFG, 32'h0000_0001);
    wr(HEFS_ADDR_LINK_CFG, 32'h0000_0000);
    $display("test async done");
    drv(5'h01);
    drv(5'h00);
    tick(1);
    chk(host_flags, 8'h80, "early upload");
    drv(5'h02);
    drv(5'h01);
    drv(5'h00);
    tick(1);
    chk(host_flags, 8'h00, "boot");
    wr(HEFS_ADDR_IRQ_CFG, 32'h0000_0001);
    drv(5'h04);
    drv(5'h00);
    tick(1);
    chk(host_flags, 8'h80, "fatal");
    chk({7'h00, host_irq}, 8'h01, "hirq on");
    rd(HEFS_ADDR_INT_STATUS, 32'h0000_0004);
    tick(1);
    chk({7'h00, host_irq}, 8'h00, "hirq off");
    wr(HEFS_ADDR_IRQ_CFG, 32'h0000_0003);
    tick(1);
    chk({7'h00, host_irq}, 8'h01, "invert");
    $display("test boot done");
    do_reset(3'h7);
    chk(host_flags, 8'h80, "warm");
    wr(HEFS_ADDR_INT_MASK, 32'h0000_0007);
    drv(5'h04);
    drv(5'h00);
    tick(1);
    chk({6'h00, irq, host_irq}, 8'h03, "retained");
    $display("test warm done");
    finish_test();
  end

endmodule : tb_top

`default_nettype wire
